/* rtl/sfs_regs.svh */
// constants of the serial flash front end link
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH

// command codes recognised by the device end
`define SFS_CMD_READ 8'h03
`define SFS_CMD_DUAL_READ 8'h3B
`define SFS_CMD_PROGRAM 8'h02

// framing counts
`define SFS_BIT_LAST 3'h7
`define SFS_ADDR_LAST 2'h2
`define SFS_HDR_BYTES 9'h004
`define SFS_PAGE_BYTES 9'h100
`define SFS_STEP_ONE 3'h1
`define SFS_STEP_DUAL 3'h2

// reset levels of the synchronised pins {sck, cs_n, lane zero}
`define SFS_PIN_RST 3'h3

// serial clock timing made by the host end
`define SFS_CLK_NS 32'h0000_000A
`define SFS_SCK_HALF_NS 32'h0000_0050
`define SFS_SCK_HALF_CYC \
  4'((`SFS_SCK_HALF_NS + `SFS_CLK_NS - 32'h0000_0001) / `SFS_CLK_NS)

`endif

/* rtl/sfs_pkg.sv */
// types shared by both ends of the serial flash link
package sfs_pkg;

  // device end states, one-hot
  typedef enum logic [6:0] {
    DS_IDLE = 7'h01,
    DS_CMD  = 7'h02,
    DS_ADDR = 7'h04,
    DS_PROG = 7'h08,
    DS_READ = 7'h10,
    DS_SKIP = 7'h20,
    DS_BUSY = 7'h40
  } sfs_dev_state_t;

  // host end states, one-hot
  typedef enum logic [7:0] {
    HS_IDLE = 8'h01,
    HS_PRE  = 8'h02,
    HS_LEAD = 8'h04,
    HS_LOAD = 8'h08,
    HS_LOW  = 8'h10,
    HS_HIGH = 8'h20,
    HS_TAIL = 8'h40,
    HS_GAP  = 8'h80
  } sfs_host_state_t;

endpackage

/* rtl/sfs_link_if.sv */
// serial link between host end and flash device end
interface sfs_link_if;
  logic sck;
  logic cs_n;
  logic host_lane_zero_o;
  logic host_lane_zero_oe;
  logic dev_lane_zero_o;
  logic dev_lane_zero_oe;
  logic dev_lane_one_o;
  logic dev_lane_one_oe;
  logic dual_lane_zero;
  logic dual_lane_one;

  // wire levels; an undriven lane reads as a pulled-up high
  assign dual_lane_zero = dev_lane_zero_oe ? dev_lane_zero_o :
                          (host_lane_zero_oe ? host_lane_zero_o : 1'h1);
  assign dual_lane_one = dev_lane_one_oe ? dev_lane_one_o : 1'h1;

  modport host (
    output sck, cs_n, host_lane_zero_o, host_lane_zero_oe,
    input dual_lane_zero, dual_lane_one
  );

  modport device (
    input sck, cs_n, dual_lane_zero,
    output dev_lane_zero_o, dev_lane_zero_oe, dev_lane_one_o, dev_lane_one_oe
  );
endinterface

/* rtl/sfs_device.sv */
// serial flash front end: device end of the serial link
`include "sfs_regs.svh"

module sfs_device (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // serial link
  sfs_link_if.device link,
  // memory core read port
  output logic o_rd_req,
  output logic [23:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  // memory core write port
  output logic o_wr_valid,
  output logic [23:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  // program cycle control
  output logic o_prog_go,
  output logic [8:0] o_prog_count,
  input wire logic i_core_busy,
  // status
  output logic o_selected,
  output logic o_standby
);

  localparam logic [2:0] PIN_RST = `SFS_PIN_RST;

  sfs_pkg::sfs_dev_state_t state;
  logic [2:0] pin_raw;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;
  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic shifting;
  logic byte_done;
  logic [7:0] in_byte;
  logic [7:0] in_shift;
  logic [2:0] bit_cnt;
  logic [1:0] addr_cnt;
  logic [23:0] cur_addr;
  logic op_dual;
  logic op_prog;
  logic [8:0] wr_count;
  logic busy_seen;
  logic addr_last;
  logic load;
  logic [2:0] out_cnt;
  logic [2:0] step;
  logic [7:0] tx_shift;
  logic [7:0] rd_buf;
  logic rd_fetch_d;
  logic drive;
  logic lane_one;
  logic lane_zero;

  // every pin passes two flops; only the second stage and its delayed copy are read
  assign pin_raw = {link.sck, link.cs_n, link.dual_lane_zero};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          pin_meta[g] <= PIN_RST[g];
          pin_sync[g] <= PIN_RST[g];
          pin_prev[g] <= PIN_RST[g];
        end else begin
          pin_meta[g] <= pin_raw[g];
          pin_sync[g] <= pin_meta[g];
          pin_prev[g] <= pin_sync[g];
        end
      end
    end
  endgenerate

  // edge finding; clock edges count only while selected, in either idle level
  assign sel = ~pin_sync[1];
  assign sck_rise = sel & pin_sync[2] & ~pin_prev[2];
  assign sck_fall = sel & ~pin_sync[2] & pin_prev[2];
  assign cs_fall = ~pin_sync[1] & pin_prev[1];
  assign cs_rise = pin_sync[1] & ~pin_prev[1];
  assign shifting = sck_rise & (state == sfs_pkg::DS_CMD || state == sfs_pkg::DS_ADDR ||
                                state == sfs_pkg::DS_PROG);
  assign byte_done = shifting & (bit_cnt == `SFS_BIT_LAST);
  assign in_byte = {in_shift[6:0], pin_sync[0]};
  assign addr_last = (state == sfs_pkg::DS_ADDR) & byte_done & (addr_cnt == `SFS_ADDR_LAST);
  assign load = sck_fall & (state == sfs_pkg::DS_READ) & (out_cnt == 3'h0);
  assign step = op_dual ? `SFS_STEP_DUAL : `SFS_STEP_ONE;

  // input shifter, realigned at the start of every frame
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      in_shift <= 8'h00;
      bit_cnt <= 3'h0;
    end else if (cs_fall) begin
      bit_cnt <= 3'h0;
    end else if (shifting) begin
      in_shift <= in_byte;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // operation sequencer
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= sfs_pkg::DS_IDLE;
    end else if (cs_rise && state != sfs_pkg::DS_IDLE && state != sfs_pkg::DS_BUSY) begin
      if (state == sfs_pkg::DS_PROG && wr_count != 9'h000) begin
        state <= sfs_pkg::DS_BUSY;
      end else begin
        state <= sfs_pkg::DS_IDLE;
      end
    end else begin
      case (state)
        sfs_pkg::DS_IDLE: begin
          if (cs_fall) begin
            state <= sfs_pkg::DS_CMD;
          end
        end
        sfs_pkg::DS_CMD: begin
          if (byte_done) begin
            case (in_byte)
              `SFS_CMD_READ, `SFS_CMD_DUAL_READ, `SFS_CMD_PROGRAM: begin
                state <= sfs_pkg::DS_ADDR;
              end
              default: begin
                state <= sfs_pkg::DS_SKIP; // unknown codes sit out the frame
              end
            endcase
          end
        end
        sfs_pkg::DS_ADDR: begin
          if (addr_last) begin
            state <= op_prog ? sfs_pkg::DS_PROG : sfs_pkg::DS_READ;
          end
        end
        sfs_pkg::DS_BUSY: begin
          // frames arriving now are ignored until the core cycle is over
          if (busy_seen && !i_core_busy) begin
            state <= sfs_pkg::DS_IDLE;
          end
        end
        sfs_pkg::DS_PROG, sfs_pkg::DS_READ, sfs_pkg::DS_SKIP: begin
          state <= state;
        end
        default: begin
          state <= sfs_pkg::DS_IDLE;
        end
      endcase
    end
  end

  // command decode
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      op_dual <= 1'h0;
      op_prog <= 1'h0;
    end else if (state == sfs_pkg::DS_CMD && byte_done) begin
      op_dual <= (in_byte == `SFS_CMD_DUAL_READ);
      op_prog <= (in_byte == `SFS_CMD_PROGRAM);
    end
  end

  // address register: loaded msb first, then advanced per data byte
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cur_addr <= 24'h00_0000;
      addr_cnt <= 2'h0;
    end else if (cs_fall) begin
      addr_cnt <= 2'h0;
    end else if (state == sfs_pkg::DS_ADDR && byte_done) begin
      cur_addr <= {cur_addr[15:0], in_byte};
      addr_cnt <= addr_cnt + 2'h1;
    end else if (state == sfs_pkg::DS_PROG && byte_done) begin
      cur_addr[7:0] <= cur_addr[7:0] + 8'h01; // wraps inside the page
    end else if (load) begin
      cur_addr <= cur_addr + 24'h00_0001;
    end
  end

  // write data to the core, one pulse per received byte
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wr_valid <= 1'h0;
      o_wr_addr <= 24'h00_0000;
      o_wr_data <= 8'h00;
      wr_count <= 9'h000;
    end else begin
      o_wr_valid <= 1'h0;
      if (cs_fall) begin
        wr_count <= 9'h000;
      end else if (state == sfs_pkg::DS_PROG && byte_done) begin
        o_wr_valid <= 1'h1;
        o_wr_addr <= cur_addr;
        o_wr_data <= in_byte;
        if (wr_count != `SFS_PAGE_BYTES) begin
          wr_count <= wr_count + 9'h001; // saturates at a full page
        end
      end
    end
  end

  // program start at frame end; the core gets two cycles to raise busy
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prog_go <= 1'h0;
      o_prog_count <= 9'h000;
      busy_seen <= 1'h0;
    end else begin
      o_prog_go <= cs_rise && state == sfs_pkg::DS_PROG && wr_count != 9'h000;
      if (cs_rise && state == sfs_pkg::DS_PROG) begin
        o_prog_count <= wr_count;
      end
      busy_seen <= (state == sfs_pkg::DS_BUSY);
    end
  end

  // read fetch: first byte right after the address, then one per loaded byte
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_req <= 1'h0;
      o_rd_addr <= 24'h00_0000;
      rd_fetch_d <= 1'h0;
      rd_buf <= 8'h00;
    end else begin
      o_rd_req <= 1'h0;
      rd_fetch_d <= o_rd_req;
      if (rd_fetch_d) begin
        rd_buf <= i_rd_data;
      end
      if (addr_last && !op_prog) begin
        o_rd_req <= 1'h1;
        o_rd_addr <= {cur_addr[15:0], in_byte};
      end else if (load) begin
        o_rd_req <= 1'h1;
        o_rd_addr <= cur_addr + 24'h00_0001;
      end
    end
  end

  // output shifter: moves only on falling clock edges
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_cnt <= 3'h0;
      tx_shift <= 8'h00;
      lane_one <= 1'h0;
      lane_zero <= 1'h0;
      drive <= 1'h0;
    end else if (state != sfs_pkg::DS_READ) begin
      out_cnt <= 3'h0;
      drive <= 1'h0;
    end else if (sck_fall) begin
      drive <= 1'h1;
      out_cnt <= out_cnt + step;
      if (out_cnt == 3'h0) begin
        lane_one <= rd_buf[7];
        lane_zero <= rd_buf[6];
        tx_shift <= op_dual ? {rd_buf[5:0], 2'h0} : {rd_buf[6:0], 1'h0};
      end else begin
        lane_one <= tx_shift[7];
        lane_zero <= tx_shift[6];
        tx_shift <= op_dual ? {tx_shift[5:0], 2'h0} : {tx_shift[6:0], 1'h0};
      end
    end
  end

  // lane drivers; lane zero turns round only in dual read
  assign link.dev_lane_one_o = lane_one;
  assign link.dev_lane_one_oe = drive;
  assign link.dev_lane_zero_o = lane_zero;
  assign link.dev_lane_zero_oe = drive & op_dual;

  // status
  assign o_selected = sel;
  assign o_standby = (state == sfs_pkg::DS_IDLE) & ~sel & ~i_core_busy;

endmodule

/* rtl/sfs_host.sv */
// serial flash front end: host end, makes clock and select
`include "sfs_regs.svh"

module sfs_host (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // serial link
  sfs_link_if.host link,
  // request
  input wire logic i_start,
  input wire logic [7:0] i_cmd,
  input wire logic [23:0] i_addr,
  input wire logic [8:0] i_len,
  input wire logic i_read,
  input wire logic i_dual,
  input wire logic i_cpol,
  output logic o_busy,
  output logic o_done,
  // write data
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_ready,
  // read data
  output logic o_rd_valid,
  output logic [7:0] o_rd_data
);

  localparam logic [3:0] HALF_LAST = `SFS_SCK_HALF_CYC - 4'h1;

  sfs_pkg::sfs_host_state_t state;
  logic [1:0] lane_meta;
  logic [1:0] lane_sync;
  logic [1:0] lane_raw;
  logic [3:0] half_cnt;
  logic phase_end;
  logic timed;
  logic [8:0] byte_idx;
  logic [8:0] end_idx;
  logic [2:0] bit_idx;
  logic [2:0] step;
  logic data_phase;
  logic [7:0] cmd;
  logic [23:0] addr;
  logic [8:0] len;
  logic rd;
  logic dual;
  logic cpol;
  logic [7:0] tx;
  logic [7:0] rx;
  logic [7:0] hdr_byte;
  logic sck;
  logic cs_n;
  logic lane0_o;
  logic lane0_oe;

  // device lanes pass two flops before use
  assign lane_raw = {link.dual_lane_one, link.dual_lane_zero};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          lane_meta[g] <= 1'h1;
          lane_sync[g] <= 1'h1;
        end else begin
          lane_meta[g] <= lane_raw[g];
          lane_sync[g] <= lane_meta[g];
        end
      end
    end
  endgenerate

  // half period timer for the clock divider
  assign timed = (state == sfs_pkg::HS_PRE) | (state == sfs_pkg::HS_LEAD) |
                 (state == sfs_pkg::HS_LOW) | (state == sfs_pkg::HS_HIGH) |
                 (state == sfs_pkg::HS_TAIL) | (state == sfs_pkg::HS_GAP);
  assign phase_end = timed & (half_cnt == HALF_LAST);
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      half_cnt <= 4'h0;
    end else if (!timed || phase_end) begin
      half_cnt <= 4'h0;
    end else begin
      half_cnt <= half_cnt + 4'h1;
    end
  end

  // header bytes go out command first, address msb first
  always_comb begin
    case (byte_idx[1:0])
      2'h0: hdr_byte = cmd;
      2'h1: hdr_byte = addr[23:16];
      2'h2: hdr_byte = addr[15:8];
      default: hdr_byte = addr[7:0];
    endcase
  end

  assign data_phase = (byte_idx >= `SFS_HDR_BYTES);
  assign end_idx = `SFS_HDR_BYTES + len;
  assign step = (data_phase && rd && dual) ? `SFS_STEP_DUAL : `SFS_STEP_ONE;

  // transfer sequencer; a missing write byte holds the clock, never skips
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= sfs_pkg::HS_IDLE;
      sck <= 1'h0;
      cs_n <= 1'h1;
      lane0_o <= 1'h1;
      lane0_oe <= 1'h1;
      byte_idx <= 9'h000;
      bit_idx <= 3'h0;
      cmd <= 8'h00;
      addr <= 24'h00_0000;
      len <= 9'h000;
      rd <= 1'h0;
      dual <= 1'h0;
      cpol <= 1'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      o_done <= 1'h0;
      o_rd_valid <= 1'h0;
      o_rd_data <= 8'h00;
    end else begin
      o_done <= 1'h0;
      o_rd_valid <= 1'h0;
      case (state)
        sfs_pkg::HS_IDLE: begin
          if (i_start) begin
            cmd <= i_cmd;
            addr <= i_addr;
            len <= i_len;
            rd <= i_read;
            dual <= i_dual & i_read;
            cpol <= i_cpol;
            sck <= i_cpol; // idle level settles before select falls
            byte_idx <= 9'h000;
            bit_idx <= 3'h0;
            state <= sfs_pkg::HS_PRE;
          end
        end
        sfs_pkg::HS_PRE: begin
          if (phase_end) begin
            cs_n <= 1'h0;
            state <= sfs_pkg::HS_LEAD;
          end
        end
        sfs_pkg::HS_LEAD: begin
          if (phase_end) begin
            state <= sfs_pkg::HS_LOAD;
          end
        end
        sfs_pkg::HS_LOAD: begin
          if (byte_idx == end_idx) begin
            sck <= cpol;
            state <= sfs_pkg::HS_TAIL;
          end else if (!data_phase) begin
            tx <= hdr_byte;
            state <= sfs_pkg::HS_LOW;
          end else if (rd) begin
            state <= sfs_pkg::HS_LOW;
          end else if (i_wr_valid) begin
            tx <= i_wr_data;
            state <= sfs_pkg::HS_LOW;
          end
        end
        sfs_pkg::HS_LOW: begin
          if (half_cnt == 4'h0) begin
            sck <= 1'h0;
            lane0_o <= tx[7];
            lane0_oe <= ~(data_phase & dual); // free lane zero for dual read
          end
          if (phase_end) begin
            rx <= dual && data_phase ? {rx[5:0], lane_sync} : {rx[6:0], lane_sync[1]};
            state <= sfs_pkg::HS_HIGH;
          end
        end
        sfs_pkg::HS_HIGH: begin
          // rise one cycle into the half, as the fall is, so both halves last eight cycles, save a high half stretched by a load
          if (half_cnt == 4'h0) begin
            sck <= 1'h1;
          end
          if (phase_end) begin
            tx <= {tx[6:0], 1'h0};
            bit_idx <= bit_idx + step;
            if (3'(bit_idx + step) == 3'h0) begin
              byte_idx <= byte_idx + 9'h001;
              if (data_phase && rd) begin
                o_rd_valid <= 1'h1;
                o_rd_data <= rx;
              end
              state <= sfs_pkg::HS_LOAD;
            end else begin
              state <= sfs_pkg::HS_LOW;
            end
          end
        end
        sfs_pkg::HS_TAIL: begin
          if (phase_end) begin
            cs_n <= 1'h1;
            state <= sfs_pkg::HS_GAP;
          end
        end
        sfs_pkg::HS_GAP: begin
          if (phase_end) begin
            lane0_oe <= 1'h1;
            o_done <= 1'h1;
            state <= sfs_pkg::HS_IDLE;
          end
        end
        default: begin
          state <= sfs_pkg::HS_IDLE;
        end
      endcase
    end
  end

  // handshakes and pins
  assign o_wr_ready = (state == sfs_pkg::HS_LOAD) & data_phase & ~rd & (byte_idx != end_idx);
  assign o_busy = (state != sfs_pkg::HS_IDLE);
  assign link.sck = sck;
  assign link.cs_n = cs_n;
  assign link.host_lane_zero_o = lane0_o;
  assign link.host_lane_zero_oe = lane0_oe;

endmodule

/* test/sfs_link_checker.sv */
// concurrent checks on the serial link joining host end and device end
module sfs_link_checker (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // link signals
  input wire logic sck,
  input wire logic cs_n,
  input wire logic host_lane_zero_o,
  input wire logic host_lane_zero_oe,
  input wire logic dev_lane_zero_o,
  input wire logic dev_lane_zero_oe,
  input wire logic dev_lane_one_o,
  input wire logic dev_lane_one_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] since_fall;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  // cycles since the serial clock fell; saturates so a long idle never wraps to a false match
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      since_fall <= 4'hf;
    end else if ($fell(sck)) begin
      since_fall <= 4'h0;
    end else if (since_fall != 4'hf) begin
      since_fall <= since_fall + 4'h1;
    end
  end

  // select held high long enough for the device to have let go
  sequence s_quiet_select;
    cs_n [*5];
  endsequence
  // clock parked at its idle level across the select edge
  sequence s_idle_clock;
    $stable(sck) [*8];
  endsequence

  a_desel_lanes_off:
    assert property (s_quiet_select |=> !dev_lane_one_oe && !dev_lane_zero_oe)
    else $error("device drives a lane while deselected");
  a_release_after_cs:
    assert property ($rose(cs_n) |-> ##[1:6] !dev_lane_one_oe)
    else $error("lane one not released after select rose");
  a_out_on_fall:
    assert property (($changed(dev_lane_one_o) || (dev_lane_zero_oe && $changed(dev_lane_zero_o)))
      && dev_lane_one_oe && $past(dev_lane_one_oe) |-> since_fall >= 4'h1 && since_fall <= 4'h6)
    else $error("output lane changed away from a falling clock");
  a_oe_on_fall:
    assert property ($rose(dev_lane_one_oe) |-> !cs_n && since_fall <= 4'h6)
    else $error("output enabled outside a selected falling edge");
  a_dual_both_lanes:
    assert property (dev_lane_zero_oe |-> dev_lane_one_oe)
    else $error("lane zero driven without lane one");
  a_no_lane_fight:
    assert property (!(host_lane_zero_oe && dev_lane_zero_oe))
    else $error("both ends drive lane zero");
  a_in_stable_rise:
    assert property ($rose(sck) && host_lane_zero_oe && !cs_n |=> $stable(host_lane_zero_o) [*3])
    else $error("input lane moved right after a rising clock");
  a_cs_fall_idle:
    assert property ($fell(cs_n) |-> s_idle_clock)
    else $error("clock moved at the select falling edge");
  a_half_period:
    assert property ($changed(sck) && !cs_n |=> $stable(sck) [*7])
    else $error("serial clock half shorter than eight cycles");
endmodule

/* test/tb_serial_flash_spi_frontend.sv */
// self-checking bench: host end and device end joined over one link
module tb_serial_flash_spi_frontend;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and host side
  logic i_clock, i_sys_rst, i_start, i_read, i_dual, i_cpol, i_wr_valid, i_core_busy;
  logic o_busy, o_done, o_wr_ready, o_rd_valid;
  logic [7:0] i_cmd, i_wr_data, o_rd_data, i_rd_data, o_wr_data;
  logic [23:0] i_addr, o_rd_addr, o_wr_addr;
  logic [8:0] i_len, o_prog_count;
  // device side and the second, bench-driven device
  logic o_rd_req, o_wr_valid, o_prog_go, o_selected, o_standby, b_req, b_wr, b_go, b_sel;
  logic [11:0] busy_cnt;
  logic [7:0] rd_q[$];
  logic [31:0] wr_q[$];
  logic [8:0] pg_q[$];
  int n_fail, n_tests, n_req, b_hits;

  sfs_link_if link();
  sfs_link_if link_b();

  sfs_host sfs_host_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(link),
    .i_start(i_start), .i_cmd(i_cmd), .i_addr(i_addr), .i_len(i_len), .i_read(i_read),
    .i_dual(i_dual), .i_cpol(i_cpol), .o_busy(o_busy), .o_done(o_done),
    .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
  sfs_device sfs_device_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(link),
    .o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data),
    .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_prog_go(o_prog_go), .o_prog_count(o_prog_count), .i_core_busy(i_core_busy),
    .o_selected(o_selected), .o_standby(o_standby));
  sfs_device sfs_device_b_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .link(link_b),
    .o_rd_req(b_req), .o_rd_addr(), .i_rd_data(8'h00), .o_wr_valid(b_wr), .o_wr_addr(),
    .o_wr_data(), .o_prog_go(b_go), .o_prog_count(), .i_core_busy(1'b0),
    .o_selected(b_sel), .o_standby());
  sfs_link_checker sfs_link_checker_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .sck(link.sck), .cs_n(link.cs_n), .host_lane_zero_o(link.host_lane_zero_o),
    .host_lane_zero_oe(link.host_lane_zero_oe), .dev_lane_zero_o(link.dev_lane_zero_o),
    .dev_lane_zero_oe(link.dev_lane_zero_oe), .dev_lane_one_o(link.dev_lane_one_o),
    .dev_lane_one_oe(link.dev_lane_one_oe));

  assign i_core_busy = (busy_cnt != 12'h000);

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // core model and monitors; the core answers a read in the next cycle
  always @(posedge i_clock) begin
    if (o_rd_req) i_rd_data <= #1 o_rd_addr[7:0] ^ 8'h5a;
    if (o_rd_req) n_req <= n_req + 1;
    if (o_rd_valid) rd_q.push_back(o_rd_data);
    if (o_wr_valid) wr_q.push_back({o_wr_addr, o_wr_data});
    if (o_prog_go) pg_q.push_back(o_prog_count);
    if (b_req || b_wr || b_go || b_sel) b_hits <= b_hits + 1;
    if (o_wr_ready && i_wr_valid) i_wr_data <= #1 i_wr_data + 8'h3c;
    // a long core cycle so a second frame lands while it still runs
    busy_cnt <= #1 o_prog_go ? 12'h7d0 : (i_core_busy ? busy_cnt - 12'h001 : 12'h000);
  end

  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one host request, waited on under a bound
  task automatic run(input logic [7:0] cmd, input logic [23:0] addr, input logic [8:0] len,
                     input logic rd, input logic dual, input logic cpol);
    logic seen_sel;
    i_cmd = cmd;
    i_addr = addr;
    i_len = len;
    i_read = rd;
    i_dual = dual;
    i_cpol = cpol;
    i_start = 1'b1;
    seen_sel = 1'b0;
    tick();
    i_start = 1'b0;
    chk(o_busy, 1'b1);
    for (int k = 0; k < 40000; k++) begin
      tick();
      seen_sel = seen_sel | o_selected;
      if (o_done === 1'b1) begin
        chk({o_busy, seen_sel}, 2'h1);
        return;
      end
    end
    chk(o_done, 1'b1);
    close_out();
  endtask

  task automatic wait_standby();
    for (int k = 0; k < 4000; k++) begin
      tick();
      if (o_standby === 1'b1) return;
    end
    chk(o_standby, 1'b1);
    close_out();
  endtask

  task automatic t_reset();
    chk(link.cs_n, 1'b1);
    chk(link.dev_lane_one_oe, 1'b0);
    chk(o_standby, 1'b1);
    chk(o_selected, 1'b0);
    $display("done reset state");
  endtask

  task automatic t_read(input logic cpol);
    rd_q.delete();
    run(8'h03, 24'h00_00fe, 9'h003, 1'b1, 1'b0, cpol);
    chk(rd_q.size(), 3);
    for (int k = 0; k < 3; k++) chk(rd_q[k], 8'(8'hfe + k) ^ 8'h5a);
    $display("done single read, idle clock %0d", cpol);
  endtask

  task automatic t_dual();
    rd_q.delete();
    run(8'h3b, 24'h00_0010, 9'h004, 1'b1, 1'b1, 1'b0);
    chk(rd_q.size(), 4);
    for (int k = 0; k < 4; k++) chk(rd_q[k], 8'(8'h10 + k) ^ 8'h5a);
    $display("done dual read");
  endtask

  // full page from near its end wraps inside the page; a frame during the cycle is dropped
  task automatic t_program();
    wr_q.delete();
    pg_q.delete();
    i_wr_valid = 1'b1;
    i_wr_data = 8'h10;
    run(8'h02, 24'h01_2ffe, 9'h100, 1'b0, 1'b0, 1'b0);
    chk(wr_q.size(), 256);
    for (int k = 0; k < 256; k++) chk(wr_q[k], {16'h012f, 8'(8'hfe + k), 8'(8'h10 + k * 60)});
    chk(pg_q.size(), 1);
    chk(pg_q[0], 9'h100);
    chk(o_standby, 1'b0);
    run(8'h02, 24'h00_0005, 9'h001, 1'b0, 1'b0, 1'b0);
    chk(wr_q.size(), 256);
    wait_standby();
    i_wr_data = 8'h77;
    run(8'h02, 24'h00_0005, 9'h001, 1'b0, 1'b0, 1'b1);
    chk(wr_q[256], {24'h00_0005, 8'h77});
    chk(pg_q[1], 9'h001);
    wait_standby();
    i_wr_valid = 1'b0;
    $display("done program");
  endtask

  // unknown command leaves lanes released; empty program starts no cycle
  task automatic t_odd();
    int n0;
    n0 = n_req;
    rd_q.delete();
    pg_q.delete();
    run(8'ha5, 24'h00_0000, 9'h001, 1'b1, 1'b0, 1'b1);
    chk(rd_q[0], 8'hff);
    chk(n_req - n0, 0);
    run(8'h02, 24'h00_0040, 9'h000, 1'b0, 1'b0, 1'b0);
    chk(pg_q.size(), 0);
    $display("done odd frames");
  endtask

  // a read frame clocked in with select left high must be ignored
  task automatic t_desel();
    logic [31:0] pat;
    pat = 32'h0300_0000;
    link_b.host_lane_zero_oe = 1'b1;
    for (int k = 0; k < 64; k++) begin
      link_b.host_lane_zero_o = pat[31 - (k % 32)];
      link_b.sck = 1'b0;
      repeat (8) tick();
      link_b.sck = 1'b1;
      repeat (8) tick();
    end
    chk(b_hits, 0);
    chk(link_b.dev_lane_one_oe, 1'b0);
    $display("done deselected input");
  endtask

  initial begin
    i_sys_rst = 1'b1;
    {i_start, i_read, i_dual, i_cpol, i_wr_valid} = 5'h00;
    {i_cmd, i_wr_data, i_rd_data} = 24'h00_0000;
    i_addr = 24'h00_0000;
    i_len = 9'h000;
    busy_cnt = 12'h000;
    {link_b.sck, link_b.cs_n, link_b.host_lane_zero_o, link_b.host_lane_zero_oe} = 4'h6;
    repeat (6) @(posedge i_clock);
    #1;
    t_reset();
    i_sys_rst = 1'b0;
    tick();
    t_read(1'b0);
    t_read(1'b1);
    t_dual();
    t_program();
    t_odd();
    t_desel();
    close_out();
  end
endmodule
